// ===== shared/seb_defs.svh
// Purpose: Constants of the two-wire EEPROM bus target
// Assumes: Included by design files by bare name
// Notes:   Counts derive from times and the 50 MHz system clock
`ifndef SEB_DEFS_SVH
`define SEB_DEFS_SVH
// ****************************************
// Protocol constants
// ****************************************
`define SEB_DEV_TYPE      4'hA
`define SEB_BITS_PER_WORD 4'h8
`define SEB_PAGE_BYTES    128
`define SEB_PAGE_BITS     7
`define SEB_ADDR_BITS     16
// ****************************************
// Timing
// ****************************************
`define SEB_CLK_MHZ       50
`define SEB_WR_CYCLE_MS   5
// Longest time; the count is an exact product, so nothing rounds
`define SEB_WR_CYC_CYCLES (`SEB_WR_CYCLE_MS * 1000 * `SEB_CLK_MHZ)
// Bus pins reset to their idle high level, so no false edge follows reset
`define SEB_SYNC_RST      6'h03
`endif

// ===== shared/seb_pkg.sv
// Purpose: Types of the two-wire EEPROM bus target
// Assumes: Nothing
// Notes:   One-hot state codes written out
package seb_pkg;
	// ****************************************
	// Target state machine
	// ****************************************
	typedef enum logic [5:0] {
		SEB_IDLE   = 6'h01, // Standby, waits for a Start
		SEB_DEVADR = 6'h02, // Receives device address
		SEB_ADRHI  = 6'h04, // Receives upper word address
		SEB_ADRLO  = 6'h08, // Receives lower word address
		SEB_DATA   = 6'h10, // Receives page data
		SEB_WRCYC  = 6'h20  // Self-timed write cycle
	} seb_state_e;
endpackage : seb_pkg

// ===== design/seb_fifo.sv
// Purpose: Small valid/ready FIFO on the array write path
// Assumes: Single clock, asynchronous active-high reset
// Notes:   Depth must be a power of two
`timescale 1ns/1ns
module seb_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             rst_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	// ****************************************
	// Parameter check
	// ****************************************
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("seb_fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem_ff [DEPTH]; // Storage
	logic [AW-1:0]    wr_ptr_ff;      // Fill pointer
	logic [AW-1:0]    rd_ptr_ff;      // Drain pointer
	logic [AW:0]      cnt_ff;         // Words held
	logic             push;
	logic             pop;
	// Full and empty from the count, never guessed
	assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_ff != '0);
	assign out_data_o  = mem_ff[rd_ptr_ff];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	// Storage write, no reset needed
	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data_i;
		end
	end
	// Pointers and count
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff    <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
			// Simultaneous push and pop leave the count alone
			if (push && !pop) begin
				cnt_ff <= cnt_ff + 1'b1;
			end else if (pop && !push) begin
				cnt_ff <= cnt_ff - 1'b1;
			end
		end
	end
endmodule : seb_fifo

// ===== design/seb_target.sv
// Purpose: Two-wire bus target of a paged serial EEPROM (write side)
// Assumes: Bus clock far slower than clk_sys_i; pins synchronised here
// Notes:   Array itself lies outside; writes leave on mem_wr_* port
//
// Behaviour
// R1: Data changes only while bus clock low
// R2: Falling data with clock high starts
// R3: Rising data with clock high stops
// R4: Eight-bit words, acknowledge on ninth clock
// R5: Standby at reset and after Stop
// R6: Master recovers with nine clocks, Start, Stop
// R7: Device address opens with fixed 1010
// R8: Next three bits match select pins
// R9: Eighth address bit: high read, low write
// R10: Match acknowledges; mismatch returns to standby
// R11: Two word-address bytes then data, acknowledged
// R12: Stop after write starts timed cycle
// R13: No acknowledge during internal write cycle
// R14: Page write takes up to 128 bytes
// R15: Only low seven address bits increment
// R16: Excess bytes wrap and overwrite page buffer
// R17: Polling acknowledged only after cycle ends
// R18: Write protect high guards whole array
// R19: Sample on rising, drive after falling
// R20: 512 pages of 128 bytes, 16-bit address
// R21: Write protect high inhibits every write
// R22: After mismatch or Stop, wait for Start
`timescale 1ns/1ns
`include "seb_defs.svh"
module seb_target #(
	parameter int WR_CYC_CNT = `SEB_WR_CYC_CYCLES,
	parameter int BUF_DEPTH  = 2
) (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	// Two-wire bus pins
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	// Straps
	input  wire logic [2:0]  device_select_pins_i,
	input  wire logic        write_protect_i,
	// Array write port
	output logic             mem_wr_valid_o,
	input  wire logic        mem_wr_ready_i,
	output logic [15:0]      mem_wr_addr_o,
	output logic [7:0]       mem_wr_data_o,
	// Status
	output logic             standby_o,
	output logic             write_busy_o
);
	// ****************************************
	// Parameter check
	// ****************************************
	if (WR_CYC_CNT < 1) begin : g_chk
		$error("seb_target write cycle count must be positive");
	end
	localparam logic [31:0] WR_CNT = 32'(WR_CYC_CNT);

	// ****************************************
	// Pin synchronisers and edge finding
	// ****************************************
	logic [5:0] sync1_ff;  // First stage, read only by second
	logic [5:0] sync2_ff;  // Second stage, safe to use
	logic       scl_d_ff;  // Previous bus clock
	logic       sda_d_ff;  // Previous bus data
	logic       scl_s;     // Synchronised bus clock
	logic       sda_s;     // Synchronised bus data
	logic [2:0] sel_s;     // Synchronised select straps
	logic       wp_s;      // Synchronised write protect
	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;
	// Two flops on every pin, straps included
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_ff <= `SEB_SYNC_RST;
			sync2_ff <= `SEB_SYNC_RST;
		end else begin
			sync1_ff <= {write_protect_i, device_select_pins_i, sda_i, scl_i};
			sync2_ff <= sync1_ff;
		end
	end
	assign scl_s = sync2_ff[0];
	assign sda_s = sync2_ff[1];
	assign sel_s = sync2_ff[4:2];
	assign wp_s  = sync2_ff[5];
	// Delayed copies; idle bus reads high
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_d_ff <= scl_s;
			sda_d_ff <= sda_s;
		end
	end
	assign scl_rise  = scl_s && !scl_d_ff; // R19
	assign scl_fall  = !scl_s && scl_d_ff; // R19
	// Data moving under a high clock is framing, not data
	assign start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s; // R1 R2
	assign stop_det  = scl_s && scl_d_ff && !sda_d_ff && sda_s; // R1 R3

	// ****************************************
	// Bit and byte reception
	// ****************************************
	seb_pkg::seb_state_e state_ff;
	logic [7:0]  shift_ff;  // Incoming word
	logic [3:0]  bit_cnt_ff; // Rising edges in this word
	logic        ack_ff;    // Drives the line low
	logic        word_done; // Falling edge after eighth bit
	logic        dev_match;
	logic [15:0] addr_ff;   // Word address
	logic [127:0] dirty_ff; // Page bytes waiting to be written
	logic        busy_done;
	assign word_done = scl_fall && (bit_cnt_ff == `SEB_BITS_PER_WORD);
	assign dev_match = (shift_ff[7:4] == `SEB_DEV_TYPE) // R7
		&& (shift_ff[3:1] == sel_s);                 // R8
	// Shift on rising edges; ninth rise is the acknowledge clock
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			shift_ff   <= 8'h00;
			bit_cnt_ff <= 4'h0;
		end else if (state_ff == seb_pkg::SEB_WRCYC) begin
			// Inputs disabled while writing
			bit_cnt_ff <= 4'h0; // R13
		end else if (start_det) begin
			bit_cnt_ff <= 4'h0;
		end else if (scl_rise) begin
			if (bit_cnt_ff < `SEB_BITS_PER_WORD) begin
				shift_ff   <= {shift_ff[6:0], sda_s}; // R4 R19
				bit_cnt_ff <= bit_cnt_ff + 4'h1;
			end else begin
				bit_cnt_ff <= 4'h0;
			end
		end
	end

	// ****************************************
	// Acknowledge drive
	// ****************************************
	// Set and released on falling edges; otherwise only Start, Stop and the write cycle clear it
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else if (state_ff == seb_pkg::SEB_WRCYC) begin
			ack_ff <= 1'b0; // R13 R17
		end else if (stop_det || start_det) begin
			ack_ff <= 1'b0;
		end else if (word_done) begin
			case (state_ff)
				seb_pkg::SEB_DEVADR: ack_ff <= dev_match; // R10
				seb_pkg::SEB_ADRHI,
				seb_pkg::SEB_ADRLO,
				seb_pkg::SEB_DATA:   ack_ff <= 1'b1; // R4 R11 R14
				default:             ack_ff <= 1'b0;
			endcase
		end else if (scl_fall) begin
			// Release after the ninth clock
			ack_ff <= 1'b0; // R1 R19
		end
	end
	// Open drain: only ever pulls low
	assign sda_o    = 1'b0;
	assign sda_oe_o = ack_ff; // R4

	// ****************************************
	// Control state machine
	// ****************************************
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= seb_pkg::SEB_IDLE; // R5
		end else begin
			case (state_ff)
				seb_pkg::SEB_WRCYC: begin
					// Starts and polls ignored until the cycle ends
					if (busy_done) begin
						state_ff <= seb_pkg::SEB_IDLE; // R5 R12 R17
					end
				end
				default: begin
					if (start_det) begin
						state_ff <= seb_pkg::SEB_DEVADR; // R2
					end else if (stop_det) begin
						if (state_ff == seb_pkg::SEB_DATA && dirty_ff != '0) begin
							state_ff <= seb_pkg::SEB_WRCYC; // R12
						end else begin
							state_ff <= seb_pkg::SEB_IDLE; // R3 R5 R22
						end
					end else if (word_done) begin
						case (state_ff)
							seb_pkg::SEB_DEVADR: begin
								// Read side is served elsewhere; writes go on
								if (dev_match && !shift_ff[0]) begin
									state_ff <= seb_pkg::SEB_ADRHI; // R9
								end else begin
									state_ff <= seb_pkg::SEB_IDLE; // R9 R10 R22
								end
							end
							seb_pkg::SEB_ADRHI: state_ff <= seb_pkg::SEB_ADRLO; // R11
							seb_pkg::SEB_ADRLO: state_ff <= seb_pkg::SEB_DATA;  // R11
							default:            state_ff <= state_ff;
						endcase
					end
				end
			endcase
		end
	end

	// ****************************************
	// Word address
	// ****************************************
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			addr_ff <= 16'h0000;
		end else if (word_done) begin
			case (state_ff)
				seb_pkg::SEB_ADRHI: addr_ff[15:8] <= shift_ff; // R20
				seb_pkg::SEB_ADRLO: addr_ff[7:0]  <= shift_ff; // R20
				seb_pkg::SEB_DATA: begin
					// Page row stays; wrap inside the page
					addr_ff[6:0] <= addr_ff[6:0] + 7'h01; // R15 R16
				end
				default: addr_ff <= addr_ff;
			endcase
		end
	end

	// ****************************************
	// Page buffer
	// ****************************************
	logic [7:0] page_mem_ff [`SEB_PAGE_BYTES]; // Bytes of one page
	logic [7:0] drain_idx_ff;               // Drain position, bit 7 ends
	logic       drain_step;
	logic       buf_in_valid;
	logic       buf_in_ready;
	logic       page_wr;
	assign page_wr = word_done && (state_ff == seb_pkg::SEB_DATA);
	// A wrapped byte simply overwrites the earlier one
	always_ff @(posedge clk_sys_i) begin
		if (page_wr) begin
			page_mem_ff[addr_ff[6:0]] <= shift_ff; // R14 R16
		end
	end
	// Marks which page bytes hold new data
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			dirty_ff <= '0;
		end else if (start_det && state_ff != seb_pkg::SEB_WRCYC) begin
			// An unfinished page before a repeated Start is dropped
			dirty_ff <= '0;
		end else if (page_wr) begin
			dirty_ff[addr_ff[6:0]] <= 1'b1; // R14
		end else if (drain_step && !drain_idx_ff[7]) begin
			dirty_ff[drain_idx_ff[6:0]] <= 1'b0;
		end
	end

	// ****************************************
	// Self-timed write cycle
	// ****************************************
	logic [31:0] wr_tmr_ff; // Cycles in the write cycle, held once it reaches WR_CNT
	logic        mem_valid;
	// Protected bytes are skipped, never offered to the array
	assign buf_in_valid = (state_ff == seb_pkg::SEB_WRCYC) && !drain_idx_ff[7]
		&& dirty_ff[drain_idx_ff[6:0]] && !wp_s; // R18 R21
	assign drain_step = (state_ff == seb_pkg::SEB_WRCYC) && !drain_idx_ff[7]
		&& (!dirty_ff[drain_idx_ff[6:0]] || wp_s || buf_in_ready);
	// Stall by the array holds the drain, so no word is lost
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			drain_idx_ff <= 8'h00;
		end else if (state_ff != seb_pkg::SEB_WRCYC) begin
			drain_idx_ff <= 8'h00;
		end else if (drain_step) begin
			drain_idx_ff <= drain_idx_ff + 8'h01;
		end
	end
	// Cycle lasts the full time even when nothing is written
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wr_tmr_ff <= 32'h0000_0000;
		end else if (state_ff != seb_pkg::SEB_WRCYC) begin
			wr_tmr_ff <= 32'h0000_0000;
		end else if (wr_tmr_ff < WR_CNT) begin
			wr_tmr_ff <= wr_tmr_ff + 32'h0000_0001; // R12
		end
	end
	// A stalled array can stretch the cycle past the nominal time
	assign busy_done = (wr_tmr_ff >= WR_CNT) && drain_idx_ff[7] && !mem_valid; // R12

	seb_fifo #(
		.WIDTH (24),
		.DEPTH (BUF_DEPTH)
	) u_wr_buf (
		.clk_sys_i   (clk_sys_i),
		.rst_i       (rst_i),
		.in_valid_i  (buf_in_valid),
		.in_ready_o  (buf_in_ready),
		.in_data_i   ({addr_ff[15:7], drain_idx_ff[6:0],
		               page_mem_ff[drain_idx_ff[6:0]]}),
		.out_valid_o (mem_valid),
		.out_ready_i (mem_wr_ready_i),
		.out_data_o  ({mem_wr_addr_o, mem_wr_data_o})
	);
	assign mem_wr_valid_o = mem_valid;

	// ****************************************
	// Status
	// ****************************************
	assign standby_o    = (state_ff == seb_pkg::SEB_IDLE);  // R5
	assign write_busy_o = (state_ff == seb_pkg::SEB_WRCYC); // R13

	// ****************************************
	// Assertions
	// ****************************************
	property p_ack_low;
		@(posedge clk_sys_i) disable iff (rst_i)
		sda_oe_o |-> !sda_o;
	endproperty
	a_ack_low: assert property (p_ack_low) // R4
		else $error("Acknowledge drives a high level");
	property p_busy_quiet;
		@(posedge clk_sys_i) disable iff (rst_i)
		write_busy_o |=> !sda_oe_o;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) // R13
		else $error("Acknowledge during write cycle");
	property p_mismatch;
		@(posedge clk_sys_i) disable iff (rst_i)
		(word_done && state_ff == seb_pkg::SEB_DEVADR && !dev_match && !start_det
			&& !stop_det) |=> (standby_o && !sda_oe_o);
	endproperty
	a_mismatch: assert property (p_mismatch) // R10
		else $error("Mismatched address not refused");
	property p_start;
		@(posedge clk_sys_i) disable iff (rst_i)
		(start_det && !write_busy_o) |=> (state_ff == seb_pkg::SEB_DEVADR);
	endproperty
	a_start: assert property (p_start) // R2
		else $error("Start not taken");
	property p_stop_idle;
		@(posedge clk_sys_i) disable iff (rst_i)
		(stop_det && !start_det && state_ff != seb_pkg::SEB_DATA && !write_busy_o)
			|=> standby_o;
	endproperty
	a_stop_idle: assert property (p_stop_idle) // R5
		else $error("Stop did not reach standby");
	property p_wr_start;
		@(posedge clk_sys_i) disable iff (rst_i)
		(stop_det && !start_det && state_ff == seb_pkg::SEB_DATA && dirty_ff != '0)
			|=> write_busy_o [*8];
	endproperty
	a_wr_start: assert property (p_wr_start) // R12
		else $error("Write cycle not held after Stop");
	property p_protect;
		@(posedge clk_sys_i) disable iff (rst_i)
		(wp_s && !mem_wr_valid_o) |=> !mem_wr_valid_o;
	endproperty
	a_protect: assert property (p_protect) // R21
		else $error("Protected byte sent to array");
	property p_wrap;
		@(posedge clk_sys_i) disable iff (rst_i)
		(page_wr && !start_det && !stop_det) |=> (addr_ff[15:7] == $past(addr_ff[15:7])
			&& addr_ff[6:0] == $past(addr_ff[6:0]) + 7'h01);
	endproperty
	a_wrap: assert property (p_wrap) // R15
		else $error("Page address did not wrap in page");
	property p_drive_low;
		@(posedge clk_sys_i) disable iff (rst_i)
		$changed(sda_oe_o) |-> !scl_s || start_det || stop_det || write_busy_o;
	endproperty
	a_drive_low: assert property (p_drive_low) // R19
		else $error("Data line moved under high clock");
endmodule : seb_target

// ===== tb/seb_master.sv
// Purpose: Behavioural two-wire bus master driving the EEPROM target
// Assumes: Open-drain wiring resolved by the bench; bus clock 160 ns per bit
// Notes:   Clock stands high between frames; ack clock gets a stretched low
`timescale 1ns/1ns
module seb_master (
	// Clock level driven directly; data drive high pulls the line low
	output logic       scl_o,
	output logic       sda_low_o,
	// Resolved data line
	input  wire logic  sda_i
);
	// ****************************************
	// Idle bus
	// ****************************************
	// Both lines released at time zero
	initial begin
		scl_o     = 1'b1;
		sda_low_o = 1'b0;
	end

	// ****************************************
	// Bus conditions
	// ****************************************
	// Data falls with clock high; works from idle or mid-frame
	task automatic start_cond();
		// Release data well after the clock fell, never at the same instant
		#40 sda_low_o = 1'b0;
		#40 scl_o = 1'b1;
		#80 sda_low_o = 1'b1;
		#80 scl_o = 1'b0;
	endtask : start_cond

	// Data rises with clock high; clock then stays high
	task automatic stop_cond();
		#40 sda_low_o = 1'b1;
		#40 scl_o = 1'b1;
		#80 sda_low_o = 1'b0;
		#80;
	endtask : stop_cond

	// One bit: data moves mid-low, sampled mid-high
	task automatic clk_bit(input logic b, output logic s);
		#40 sda_low_o = ~b;
		#40 scl_o = 1'b1;
		#40 s = sda_i;
		#40 scl_o = 1'b0;
	endtask : clk_bit

	// MSB first, then a released ninth bit; low stretched so the ack clears
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], s);
		end
		clk_bit(1'b1, s);
		ack = ~s;
		#100;
	endtask : send_byte

	// Nine free clocks with data released
	task automatic nine_clocks();
		logic s;
		repeat (9) clk_bit(1'b1, s);
	endtask : nine_clocks
endmodule : seb_master

// ===== tb/seb_target_tb_top.sv
// Purpose: Self-checking bench of the two-wire EEPROM target (write side)
// Assumes: Write cycle shortened to 200 clocks
// Notes:   Array writes checked in order against a queue of expected words
`timescale 1ns/1ns
module seb_target_tb_top;
	// ****************************************
	// Signals
	// ****************************************
	logic        clk_sys_i;  // 50 MHz system clock
	logic        rst_i;      // Active-high reset
	logic        m_scl;      // Master clock drive
	logic        m_low;      // Master pulls data low
	wire         sda_w;      // Resolved data line
	logic        sda_o;      // Target data value
	logic        sda_oe;     // Target pulls data low
	logic [2:0]  sel;        // Select straps
	logic        wp;         // Write protect
	logic        wr_valid;   // Array write offered
	logic        wr_ready;   // Array accepts
	logic [15:0] wr_addr;    // Array address
	logic [7:0]  wr_data;    // Array byte
	logic        standby;    // Standby flag
	logic        busy;       // Write cycle flag
	logic [31:0] seed = 32'h36A49CA1; // Xorshift state
	logic [23:0] exp_q[$];   // Expected array writes
	int          fail_count;
	int          samples_checked;

	// Pull-up: line is high unless someone pulls it low
	assign sda_w = (m_low | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;

	// ****************************************
	// Instances
	// ****************************************
	seb_target #(.WR_CYC_CNT(200), .BUF_DEPTH(2)) i_seb_target (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(m_scl), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_o(sda_oe), .device_select_pins_i(sel),
		.write_protect_i(wp), .mem_wr_valid_o(wr_valid), .mem_wr_ready_i(wr_ready),
		.mem_wr_addr_o(wr_addr), .mem_wr_data_o(wr_data), .standby_o(standby),
		.write_busy_o(busy)
	);
	seb_master i_seb_master (.scl_o(m_scl), .sda_low_o(m_low), .sda_i(sda_w));

	// ****************************************
	// Helpers
	// ****************************************
	// Clock
	always #10 clk_sys_i = ~clk_sys_i;

	function automatic void roll();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
	endfunction : roll

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic close_out();
		if (fail_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out

	// Sends one byte and compares the ninth-bit answer
	task automatic xfer(input logic [7:0] d, input logic exp_ack);
		logic a;
		i_seb_master.send_byte(d, a);
		check({23'h0, a}, {23'h0, exp_ack});
	endtask : xfer

	// Page write; expected words queued in page offset order before the Stop
	task automatic page_write(input logic [15:0] adr, input int n);
		logic [7:0] pg [128];
		logic       dirty [128];
		logic [6:0] off;
		foreach (dirty[k]) dirty[k] = 1'b0;
		i_seb_master.start_cond();
		xfer({4'hA, sel, 1'b0}, 1'b1);
		xfer(adr[15:8], 1'b1);
		xfer(adr[7:0], 1'b1);
		for (int k = 0; k < n; k++) begin
			off = adr[6:0] + 7'(k);
			roll();
			pg[off] = seed[7:0];
			dirty[off] = 1'b1;
			xfer(pg[off], 1'b1);
		end
		// Protected writes leave nothing to expect
		for (int k = 0; k < 128; k++) begin
			if (!wp && dirty[k]) exp_q.push_back({adr[15:7], 7'(k), pg[k]});
		end
		i_seb_master.stop_cond();
		repeat (2) @(negedge clk_sys_i);
		check({23'h0, busy}, 24'h1);
	endtask : page_write

	// Bounded wait for the write cycle and drain to finish
	task automatic wait_idle();
		int i;
		i = 0;
		while (busy !== 1'b0 && i < 3000) begin
			@(negedge clk_sys_i);
			i++;
		end
		repeat (4) @(negedge clk_sys_i);
		check({23'h0, standby}, 24'h1);
		check(24'(exp_q.size()), 24'h0);
	endtask : wait_idle

	// ****************************************
	// Array side: random stalls, in-order compare
	// ****************************************
	always @(negedge clk_sys_i) begin
		roll();
		wr_ready <= seed[3] | seed[9];
	end

	// Unexpected writes compare against unknown and so always fail
	always @(posedge clk_sys_i) begin
		if (!rst_i && wr_valid === 1'b1 && wr_ready)
			check({wr_addr, wr_data}, (exp_q.size() != 0) ? exp_q.pop_front() : 24'hX);
	end

	// ****************************************
	// Watchdog
	// ****************************************
	initial begin
		#1000000;
		fail_count++;
		close_out();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic s;
		logic [7:0] bad [3];
		clk_sys_i = 1'b0;
		rst_i = 1'b1;
		wp = 1'b0;
		wr_ready = 1'b0;
		roll();
		sel = seed[2:0];
		repeat (20) @(negedge clk_sys_i);
		rst_i = 1'b0;
		repeat (6) @(negedge clk_sys_i);
		check({23'h0, standby}, 24'h1);
		// Wrong type code or wrong straps: no ack, standby
		bad[0] = {4'hA, sel ^ 3'h1, 1'b0};
		bad[1] = {4'h2, sel, 1'b0};
		bad[2] = {4'hB, sel, 1'b1};
		foreach (bad[i]) begin
			i_seb_master.start_cond();
			xfer(bad[i], 1'b0);
			xfer(8'h00, 1'b0);
			i_seb_master.stop_cond();
			check({23'h0, standby}, 24'h1);
		end
		// Read request acknowledged on match
		i_seb_master.start_cond();
		xfer({4'hA, sel, 1'b1}, 1'b1);
		i_seb_master.stop_cond();
		// Byte write, then polling during and after the cycle
		page_write(16'h0040, 1);
		i_seb_master.start_cond();
		xfer({4'hA, sel, 1'b0}, 1'b0);
		i_seb_master.stop_cond();
		wait_idle();
		i_seb_master.start_cond();
		xfer({4'hA, sel, 1'b0}, 1'b1);
		i_seb_master.stop_cond();
		repeat (4) @(negedge clk_sys_i);
		check({23'h0, busy}, 24'h0);
		// Overlong page write from near the page end
		roll();
		page_write({seed[8:0], 7'h7E}, 130);
		wait_idle();
		// Protected page write: acks, no array writes
		@(negedge clk_sys_i);
		wp = 1'b1;
		page_write(16'h2310, 3);
		wait_idle();
		@(negedge clk_sys_i);
		wp = 1'b0;
		// Aborted frame, recovery, then a wrapping write
		i_seb_master.start_cond();
		repeat (3) i_seb_master.clk_bit(1'b0, s);
		i_seb_master.start_cond();
		i_seb_master.nine_clocks();
		i_seb_master.start_cond();
		i_seb_master.stop_cond();
		page_write(16'hFFFF, 2);
		wait_idle();
		close_out();
	end
endmodule : seb_target_tb_top
